// ---- verification/bbfc_fetch_model.sv ----
`timescale 1ns/1ps
module bbfc_fetch_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        redirect_valid,
  input  wire logic [63:0] redirect_target,
  input  wire logic        bkpt_exception,
  input  wire logic [31:0] trap_word,
  output logic      [63:0] fetch_pc,
  output logic      [19:0] bkpt_code
);
  // fetch follows redirects; the handler takes its code from the trapping word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_pc  <= 64'h0;
      bkpt_code <= 20'h0;
    end else begin
      if (redirect_valid) fetch_pc <= redirect_target;
      if (bkpt_exception) bkpt_code <= trap_word[25:6];
    end
  end
endmodule // bbfc_fetch_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import bbfc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, inv, res;
  logic rv, sn, bk, fi, ri;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat, last_word, insn, brk;
  logic [63:0] tgt_o, fetch_pc, pc, ga, gb, tg;
  logic [19:0] bkpt_code;
  logic [68:0] expq[$];
  logic [68:0] e;
  logic [15:0] off;
  logic [4:0] ev;
  logic [3:0] c;
  logic [2:0] cidx;
  logic [31:0] opa[4] = '{32'h3f80_0000, 32'h0, 32'h4000_0000, 32'h7fc0_0000};
  logic [31:0] opb[4] = '{32'h4000_0000, 32'h8000_0000, 32'h3f80_0000, 32'h7fc0_0000};
  logic [2:0] rel[4] = '{3'h4, 3'h2, 3'h0, 3'h1};
  int err_total, n_tests, seed, j;
  bbfc_exec i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .redirect_valid(rv), .redirect_target(tgt_o), .slot_nullify(sn), .bkpt_exception(bk),
    .fp_invalid_exception(fi), .reserved_instr(ri));
  bbfc_fetch_model i_fetch (.pclk(pclk), .presetn(presetn), .redirect_valid(rv),
    .redirect_target(tgt_o), .bkpt_exception(bk), .trap_word(last_word), .fetch_pc(fetch_pc),
    .bkpt_code(bkpt_code));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task automatic check(input logic [63:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == ADDR_INSTR) begin
      last_word = d;
      repeat (3) @(posedge pclk);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
    apb(1'b0, a, 32'h0);
    check(rdat, exp);
    check(er, eexp);
  endtask
  task automatic br(input logic [31:0] ins, slot, input logic [68:0] ex);
    wr(ADDR_PC_LO, pc[31:0]);
    wr(ADDR_PC_HI, pc[63:32]);
    wr(ADDR_GPR1_LO, ga[31:0]);
    wr(ADDR_GPR1_HI, ga[63:32]);
    wr(ADDR_GPR2_LO, gb[31:0]);
    wr(ADDR_GPR2_HI, gb[63:32]);
    wr(ADDR_INSTR, ins);
    if (ex[68:64] != 5'h0) expq.push_back(ex);
    wr(ADDR_INSTR, slot);
  endtask
  task automatic fcmp(input logic [4:0] fmt, input logic [63:0] a, b, input logic [9:0] csr);
    wr(ADDR_FS_LO, a[31:0]);
    wr(ADDR_FS_HI, a[63:32]);
    wr(ADDR_FT_LO, b[31:0]);
    wr(ADDR_FT_HI, b[63:32]);
    wr(ADDR_FPCSR, {22'h0, csr});
    wr(ADDR_INSTR, {OP_FP_COP, fmt, 5'h2, 5'h1, cidx, 2'h0, CMP_TAG, c});
  endtask
  // each pulse group is matched against the oldest expectation
  always @(posedge pclk) begin
    if (presetn && {rv, sn, bk, fi, ri} != 5'h0) begin
      e = (expq.size() > 0) ? expq.pop_front() : 69'h0;
      check({59'h0, rv, sn, bk, fi, ri}, {59'h0, e[68:64]});
      if (e[68]) check(tgt_o, e[63:0]);
    end
  end
  // watchdog
  initial begin
    repeat (30000) @(posedge pclk);
    err_total++;
    report_and_stop();
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, last_word} = '0;
    seed = 32'hba9c;
    presetn = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdc(ADDR_FPCSR, 32'h0, 1'b0);
    rdc(8'h3c, 32'h0, 1'b1);
    // branch table: negative likely, unequal, unequal likely, break in slot
    for (int i = 0; i < 7; i++) begin
      pc = {$random(seed), $random(seed)} & ~64'h3;
      off = $random(seed);
      ga = (i < 2 || i == 6) ? {i[0] ? 32'h0 : 32'h8000_0000, 32'hffff_ffff} : 64'h5a;
      gb = (i == 2) ? 64'h8000_0000_0000_005a : (i == 5) ? 64'h5b : 64'h5a;
      ev = (i == 1 || i == 4) ? 5'h08 : (i == 3 || i == 6) ? 5'h04 : 5'h10;
      insn = {(i < 2 || i == 6) ? {OP_REG_IMM, 5'h3, RI_NEG_LIKELY} :
              {(i < 4) ? OP_UNEQUAL : OP_UNEQ_LIKELY, 5'h3, 5'h4}, off};
      brk = {OP_SPECIAL, 20'($random(seed)), FN_BREAK};
      tg = pc + 64'h4 + {{46{off[15]}}, off, 2'h0};
      br(insn, (ev == 5'h10) ? 32'h0 : brk, {ev, tg});
      if (ev == 5'h04) check(bkpt_code, brk[25:6]);
      if (ev == 5'h10) check(fetch_pc, tg);
      rdc(ADDR_TGT_LO, tg[31:0], 1'b0);
    end
    expq.push_back({5'h04, 64'h0});
    wr(ADDR_INSTR, brk);
    // all sixteen predicates over lt, eq, gt and unordered operands
    for (int k = 0; k < 64; k++) begin
      j = k / 16;
      c = k[3:0];
      cidx = $random(seed);
      fcmp(FMT_SINGLE, {32'h0, opa[j]}, {32'h0, opb[j]}, 10'h0);
      inv = (j == 3) && c[3];
      res = |(c[2:0] & rel[j]);
      rdc(ADDR_FPCSR, {22'h0, 1'b0, inv, 8'({7'h0, res} << cidx)}, 1'b0);
    end
    c = 4'h1;
    cidx = 3'h1;
    expq.push_back({5'h02, 64'h0});
    fcmp(FMT_SINGLE, 64'h7fa0_0000, 64'h3f80_0000, 10'h200);
    rdc(ADDR_FPCSR, 32'h300, 1'b0);
    c = 4'h2;
    cidx = 3'h2;
    fcmp(FMT_PAIRED, 64'h3f80_0000_3f80_0000, 64'h3f80_0000_4000_0000, 10'h0);
    rdc(ADDR_FPCSR, 32'h8, 1'b0);
    c = 4'h4;
    cidx = 3'h7;
    fcmp(FMT_DOUBLE, 64'hbff0_0000_0000_0000, 64'h3ff0_0000_0000_0000, 10'h0);
    rdc(ADDR_FPCSR, 32'h80, 1'b0);
    expq.push_back({5'h01, 64'h0});
    fcmp(5'h00, 64'h0, 64'h0, 10'h0);
    check(expq.size(), 64'h0);
    report_and_stop();
  end
endmodule // tb

// ---- verilog/bbfc_exec.sv ----
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
module bbfc_exec (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [bbfc_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [bbfc_pkg::DATA_W-1:0]   pwdata,
  output logic      [bbfc_pkg::DATA_W-1:0]   prdata,
  output logic                               pready,
  output logic                               pslverr,
  output logic                               redirect_valid,
  output logic      [63:0]                   redirect_target,
  output logic                               slot_nullify,
  output logic                               bkpt_exception,
  output logic                               fp_invalid_exception,
  output logic                               reserved_instr
);
  import bbfc_pkg::*;

  logic [31:0]          instr_reg;
  logic                 go_reg;
  logic [63:0]          gpr_first_reg;
  logic [63:0]          gpr_second_reg;
  logic [63:0]          fs_reg;
  logic [63:0]          ft_reg;
  logic [63:0]          pc_reg;
  logic [63:0]          target_reg;
  logic [FPCSR_W-1:0]   fpcsr_reg;
  logic [EVT_W-1:0]     evt_reg;
  logic                 slot_taken_reg;
  logic                 slot_likely_reg;
  logic [31:0]          prdata_reg;
  logic                 err_reg;
  logic                 redirect_reg;
  logic                 nullify_reg;
  logic                 bkpt_reg;
  logic                 fpe_reg;
  logic                 resv_reg;
  bbfc_state_t          state_reg;
  bbfc_state_t          state_next;

  // apb address decode
  wire logic sel_instr  = (paddr == ADDR_INSTR);
  wire logic sel_g1_lo  = (paddr == ADDR_GPR1_LO);
  wire logic sel_g1_hi  = (paddr == ADDR_GPR1_HI);
  wire logic sel_g2_lo  = (paddr == ADDR_GPR2_LO);
  wire logic sel_g2_hi  = (paddr == ADDR_GPR2_HI);
  wire logic sel_fs_lo  = (paddr == ADDR_FS_LO);
  wire logic sel_fs_hi  = (paddr == ADDR_FS_HI);
  wire logic sel_ft_lo  = (paddr == ADDR_FT_LO);
  wire logic sel_ft_hi  = (paddr == ADDR_FT_HI);
  wire logic sel_pc_lo  = (paddr == ADDR_PC_LO);
  wire logic sel_pc_hi  = (paddr == ADDR_PC_HI);
  wire logic sel_fpcsr  = (paddr == ADDR_FPCSR);
  wire logic sel_status = (paddr == ADDR_STATUS);
  wire logic sel_tgt_lo = (paddr == ADDR_TGT_LO);
  wire logic sel_tgt_hi = (paddr == ADDR_TGT_HI);
  wire logic addr_ok    = sel_instr | sel_g1_lo | sel_g1_hi | sel_g2_lo | sel_g2_hi | sel_fs_lo | sel_fs_hi
                        | sel_ft_lo | sel_ft_hi | sel_pc_lo | sel_pc_hi | sel_fpcsr | sel_status
                        | sel_tgt_lo | sel_tgt_hi;
  wire logic setup      = psel & ~penable;
  wire logic wr_en      = psel & penable & pwrite & addr_ok;
  wire logic fpcsr_wr   = wr_en & sel_fpcsr;

  // read data selection, captured in the setup cycle
  wire logic [31:0] status_word = {25'h0000000, evt_reg, slot_taken_reg, state_reg == ST_SLOT};
  wire logic [31:0] rd_mux =
      sel_instr  ? instr_reg            : sel_g1_lo ? gpr_first_reg[31:0]  : sel_g1_hi ? gpr_first_reg[63:32]  :
      sel_g2_lo  ? gpr_second_reg[31:0] : sel_g2_hi ? gpr_second_reg[63:32] :
      sel_fs_lo  ? fs_reg[31:0]         : sel_fs_hi ? fs_reg[63:32]        :
      sel_ft_lo  ? ft_reg[31:0]         : sel_ft_hi ? ft_reg[63:32]        :
      sel_pc_lo  ? pc_reg[31:0]         : sel_pc_hi ? pc_reg[63:32]        :
      sel_fpcsr  ? {22'h000000, fpcsr_reg} : sel_status ? status_word      :
      sel_tgt_lo ? target_reg[31:0]     : sel_tgt_hi ? target_reg[63:32]   : RST_WORD;

  assign pready  = psel & penable;
  assign prdata  = prdata_reg;
  assign pslverr = psel & penable & err_reg;

  // read data and error flag flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= RST_WORD;
      err_reg    <= 1'b0;
    end else if (setup) begin
      prdata_reg <= rd_mux;
      err_reg    <= ~addr_ok;
    end
  end

  // software-written operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpr_first_reg  <= RST_DWORD;
      gpr_second_reg <= RST_DWORD;
      fs_reg         <= RST_DWORD;
      ft_reg         <= RST_DWORD;
      pc_reg         <= RST_DWORD;
    end else if (wr_en) begin
      if (sel_g1_lo) gpr_first_reg[31:0]   <= pwdata;
      if (sel_g1_hi) gpr_first_reg[63:32]  <= pwdata;
      if (sel_g2_lo) gpr_second_reg[31:0]  <= pwdata;
      if (sel_g2_hi) gpr_second_reg[63:32] <= pwdata;
      if (sel_fs_lo) fs_reg[31:0]          <= pwdata;
      if (sel_fs_hi) fs_reg[63:32]         <= pwdata;
      if (sel_ft_lo) ft_reg[31:0]          <= pwdata;
      if (sel_ft_hi) ft_reg[63:32]         <= pwdata;
      if (sel_pc_lo) pc_reg[31:0]          <= pwdata;
      if (sel_pc_hi) pc_reg[63:32]         <= pwdata;
    end
  end

  // writing the instruction word launches it on the next cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_reg <= RST_WORD;
      go_reg    <= 1'b0;
    end else begin
      if (wr_en && sel_instr) instr_reg <= pwdata;
      go_reg <= wr_en & sel_instr;
    end
  end

  // instruction decode
  wire logic [5:0]  opc       = instr_reg[OPC_LSB +: 6];
  wire logic [3:0]  cond      = instr_reg[COND_LSB +: 4];
  wire logic [4:0]  fmt       = instr_reg[FMT_LSB +: 5];
  wire logic [2:0]  cc_idx    = instr_reg[CC_LSB +: 3];
  wire logic [2:0]  cc_idx_hi = cc_idx + 3'h1; // odd index: unpredictable, wraps
  wire logic        is_neg_l  = (opc == OP_REG_IMM) && (instr_reg[RT_LSB +: 5] == RI_NEG_LIKELY);
  wire logic        is_uneq   = (opc == OP_UNEQUAL);
  wire logic        is_uneq_l = (opc == OP_UNEQ_LIKELY);
  wire logic        is_branch = is_neg_l | is_uneq | is_uneq_l;
  wire logic        is_break  = (opc == OP_SPECIAL) && (instr_reg[FUNC_LSB +: 6] == FN_BREAK);
  wire logic        is_s      = (fmt == FMT_SINGLE);
  wire logic        is_d      = (fmt == FMT_DOUBLE);
  wire logic        is_ps     = (fmt == FMT_PAIRED);
  wire logic        cmp_shape = (opc == OP_FP_COP) && (instr_reg[TAG_LSB +: 2] == CMP_TAG)
                              && (instr_reg[ZERO_LSB +: 2] == 2'h0);
  wire logic        is_fcmp   = cmp_shape & (is_s | is_d | is_ps);
  wire logic        in_slot   = (state_reg == ST_SLOT);

  // branch condition and target
  wire logic        neg_sign  = gpr_first_reg[63];
  wire logic        unequal   = (gpr_first_reg != gpr_second_reg);
  wire logic        br_cond   = is_neg_l ? neg_sign : unequal;
  wire logic        br_likely = is_neg_l | is_uneq_l;
  wire logic [63:0] offset_ext = {{46{instr_reg[OFS_LSB + 15]}}, instr_reg[OFS_LSB +: 16], 2'b00};
  wire logic [63:0] target_calc = pc_reg + SLOT_STEP + offset_ext;

  // a not-taken likely branch kills its slot instruction
  wire logic        nullified = in_slot & slot_likely_reg & ~slot_taken_reg;
  wire logic        live      = go_reg & ~nullified;
  wire logic        exec_br   = live & is_branch & ~in_slot;

  // floating-point compare units: low single, high single, double
  logic lo_lt, lo_eq, lo_un, lo_sn, lo_qn;
  logic hi_lt, hi_eq, hi_un, hi_sn, hi_qn;
  logic d_lt, d_eq, d_un, d_sn, d_qn;
  bbfc_fp_cmp #(.EXP_W(EXP_S), .MAN_W(MAN_S)) u_cmp_lo (
    .op_a (fs_reg[31:0]),
    .op_b (ft_reg[31:0]),
    .lt   (lo_lt),
    .eq   (lo_eq),
    .un   (lo_un),
    .snan (lo_sn),
    .qnan (lo_qn)
  );
  bbfc_fp_cmp #(.EXP_W(EXP_S), .MAN_W(MAN_S)) u_cmp_hi (
    .op_a (fs_reg[63:32]),
    .op_b (ft_reg[63:32]),
    .lt   (hi_lt),
    .eq   (hi_eq),
    .un   (hi_un),
    .snan (hi_sn),
    .qnan (hi_qn)
  );
  bbfc_fp_cmp #(.EXP_W(EXP_D), .MAN_W(MAN_D)) u_cmp_d (
    .op_a (fs_reg),
    .op_b (ft_reg),
    .lt   (d_lt),
    .eq   (d_eq),
    .un   (d_un),
    .snan (d_sn),
    .qnan (d_qn)
  );

  // predicate evaluation and invalid detection
  wire logic s_lt   = is_d ? d_lt : lo_lt;
  wire logic s_eq   = is_d ? d_eq : lo_eq;
  wire logic s_un   = is_d ? d_un : lo_un;
  wire logic s_sn   = is_d ? d_sn : lo_sn;
  wire logic s_qn   = is_d ? d_qn : lo_qn;
  wire logic res_lo = (cond[2] & s_lt) | (cond[1] & s_eq) | (cond[0] & s_un);
  wire logic res_hi = (cond[2] & hi_lt) | (cond[1] & hi_eq) | (cond[0] & hi_un);
  wire logic inv_lo = s_sn | (cond[3] & s_qn);
  wire logic inv_hi = hi_sn | (cond[3] & hi_qn);
  wire logic inv    = inv_lo | (is_ps & inv_hi);
  wire logic cmp_go = live & is_fcmp;
  wire logic fpe_now = cmp_go & inv & fpcsr_reg[FPCSR_EN];
  wire logic write_cc = cmp_go & ~fpe_now;
  // condition-code merge; hardware update wins over a same-cycle software write
  wire logic [7:0] cc_base  = fpcsr_wr ? pwdata[7:0] : fpcsr_reg[FPCSR_CC_LSB +: 8];
  wire logic [7:0] mask_lo  = 8'h01 << cc_idx;
  wire logic [7:0] mask_hi  = is_ps ? (8'h01 << cc_idx_hi) : 8'h00;
  wire logic [7:0] cc_val   = ({8{res_lo}} & mask_lo) | ({8{res_hi}} & mask_hi);
  wire logic [7:0] cc_next  = write_cc ? ((cc_base & ~(mask_lo | mask_hi)) | cc_val) : cc_base;
  wire logic       flag_next = (fpcsr_wr ? pwdata[FPCSR_FLAG] : fpcsr_reg[FPCSR_FLAG]) | (cmp_go & inv);
  wire logic       en_next   = fpcsr_wr ? pwdata[FPCSR_EN] : fpcsr_reg[FPCSR_EN];
  // breakpoint and fp invalid exceptions in a slot cancel the pending redirect; a reserved instruction does not
  wire logic bkpt_now  = live & is_break;
  wire logic resv_now  = live & cmp_shape & ~is_fcmp;
  wire logic redir_now = go_reg & in_slot & slot_taken_reg & ~bkpt_now & ~fpe_now;

  // fp control/status register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fpcsr_reg <= RST_FPCSR;
    else          fpcsr_reg <= {en_next, flag_next, cc_next};
  end

  // branch sequencing state
  always_comb begin
    case (state_reg)
      ST_IDLE: state_next = exec_br ? ST_SLOT : ST_IDLE;
      ST_SLOT: state_next = go_reg ? ST_IDLE : ST_SLOT;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg       <= ST_IDLE;
      slot_taken_reg  <= 1'b0;
      slot_likely_reg <= 1'b0;
      target_reg      <= RST_DWORD;
    end else begin
      state_reg <= state_next;
      if (exec_br) begin
        slot_taken_reg  <= br_cond;
        slot_likely_reg <= br_likely;
        target_reg      <= target_calc;
      end
    end
  end

  // event pulses and last-event record
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      redirect_reg <= 1'b0;
      nullify_reg  <= 1'b0;
      bkpt_reg     <= 1'b0;
      fpe_reg      <= 1'b0;
      resv_reg     <= 1'b0;
      evt_reg      <= RST_EVT;
    end else begin
      redirect_reg <= redir_now;
      nullify_reg  <= go_reg & nullified;
      bkpt_reg     <= bkpt_now;
      fpe_reg      <= fpe_now;
      resv_reg     <= resv_now;
      if (go_reg) evt_reg <= {resv_now, fpe_now, bkpt_now, nullified, redir_now};
    end
  end

  assign redirect_valid       = redirect_reg;
  assign redirect_target      = target_reg;
  assign slot_nullify         = nullify_reg;
  assign bkpt_exception       = bkpt_reg;
  assign fp_invalid_exception = fpe_reg;
  assign reserved_instr       = resv_reg;

  // checks
  a_target_form: assert property (@(posedge pclk) disable iff (!presetn)
    exec_br |=> target_reg == $past(pc_reg) + SLOT_STEP + $past(offset_ext))
    else $error("branch target wrong");
  a_neg_sign_taken: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_br && is_neg_l) |=> (slot_taken_reg == $past(gpr_first_reg[63])) && slot_likely_reg)
    else $error("negative likely condition wrong");
  a_slot_nullified: assert property (@(posedge pclk) disable iff (!presetn)
    (go_reg && in_slot && slot_likely_reg && !slot_taken_reg) |=>
      slot_nullify && !bkpt_exception && !fp_invalid_exception && !redirect_valid && $stable(fpcsr_reg))
    else $error("likely slot not nullified");
  a_redirect_after_slot: assert property (@(posedge pclk) disable iff (!presetn)
    (in_slot && slot_taken_reg) |-> !redirect_valid)
    else $error("redirect before slot");
  a_redirect_cause: assert property (@(posedge pclk) disable iff (!presetn)
    redirect_valid |-> $past(go_reg) && $past(state_reg == ST_SLOT) && $past(slot_taken_reg))
    else $error("redirect without taken slot");
  a_unequal_plain: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_br && is_uneq) |=> (slot_taken_reg == $past(unequal)) && !slot_likely_reg)
    else $error("unequal branch wrong");
  a_unequal_likely: assert property (@(posedge pclk) disable iff (!presetn)
    (exec_br && is_uneq_l) |=> (slot_taken_reg == $past(unequal)) && slot_likely_reg)
    else $error("unequal likely wrong");
  a_break_raise: assert property (@(posedge pclk) disable iff (!presetn)
    (live && is_break) |=> bkpt_exception ##1 !bkpt_exception)
    else $error("breakpoint not raised once");
  a_cc_write_low: assert property (@(posedge pclk) disable iff (!presetn)
    write_cc |=> fpcsr_reg[$past(cc_idx)] == $past(res_lo))
    else $error("condition code not written");
  a_cc_write_high: assert property (@(posedge pclk) disable iff (!presetn)
    (write_cc && is_ps) |=> fpcsr_reg[$past(cc_idx_hi)] == $past(res_hi))
    else $error("upper half code not written");
  a_invalid_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_go && (s_sn || (cond[3] && s_qn))) |=> fpcsr_reg[FPCSR_FLAG])
    else $error("invalid flag not set");
  a_invalid_trap: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_go && inv && fpcsr_reg[FPCSR_EN] && !fpcsr_wr) |=>
      fp_invalid_exception && $stable(fpcsr_reg[FPCSR_CC_LSB +: 8]))
    else $error("enabled invalid wrote result");
  a_unordered_excl: assert property (@(posedge pclk) disable iff (!presetn)
    cmp_go |-> !(s_lt && s_eq) && (s_un == (!s_lt && !s_eq && s_un)))
    else $error("ordering relations overlap");
  a_zero_equal: assert property (@(posedge pclk) disable iff (!presetn)
    (cmp_go && is_s && fs_reg[30:0] == 31'h00000000 && ft_reg[30:0] == 31'h00000000) |-> lo_eq && !lo_lt)
    else $error("signed zeros unequal");
endmodule // bbfc_exec

// ---- verilog/bbfc_fp_cmp.sv ----
`timescale 1ns/1ps
module bbfc_fp_cmp #(
  parameter int EXP_W = 8,
  parameter int MAN_W = 23
) (
  input  wire logic [EXP_W+MAN_W:0] op_a,
  input  wire logic [EXP_W+MAN_W:0] op_b,
  output logic                      lt,
  output logic                      eq,
  output logic                      un,
  output logic                      snan,
  output logic                      qnan
);
  localparam int W = EXP_W + MAN_W + 1;

  // field split and nan classes
  wire logic [EXP_W-1:0] exp_a  = op_a[W-2 -: EXP_W];
  wire logic [EXP_W-1:0] exp_b  = op_b[W-2 -: EXP_W];
  wire logic [MAN_W-1:0] man_a  = op_a[MAN_W-1:0];
  wire logic [MAN_W-1:0] man_b  = op_b[MAN_W-1:0];
  wire logic [W-2:0]     mag_a  = op_a[W-2:0];
  wire logic [W-2:0]     mag_b  = op_b[W-2:0];
  wire logic             nan_a  = (&exp_a) & (|man_a);
  wire logic             nan_b  = (&exp_b) & (|man_b);
  wire logic             zero_2 = ~(|mag_a) & ~(|mag_b);

  // exact magnitude compare, no rounding so no overflow or underflow
  wire logic             eq_raw = zero_2 | (op_a == op_b);
  wire logic             lt_raw = (op_a[W-1] != op_b[W-1]) ? (op_a[W-1] & ~zero_2) :
                                  (op_a[W-1] ? (mag_a > mag_b) : (mag_a < mag_b));

  // unordered excludes the other relations
  assign un   = nan_a | nan_b;
  assign eq   = ~un & eq_raw;
  assign lt   = ~un & lt_raw;
  assign snan = (nan_a & ~man_a[MAN_W-1]) | (nan_b & ~man_b[MAN_W-1]);
  assign qnan = (nan_a & man_a[MAN_W-1]) | (nan_b & man_b[MAN_W-1]);
endmodule // bbfc_fp_cmp

// ---- verilog/bbfc_pkg.sv ----
package bbfc_pkg;

  // apb side
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam logic [7:0]  ADDR_INSTR    = 8'h00;
  localparam logic [7:0]  ADDR_GPR1_LO  = 8'h04;
  localparam logic [7:0]  ADDR_GPR1_HI  = 8'h08;
  localparam logic [7:0]  ADDR_GPR2_LO  = 8'h0c;
  localparam logic [7:0]  ADDR_GPR2_HI  = 8'h10;
  localparam logic [7:0]  ADDR_FS_LO    = 8'h14;
  localparam logic [7:0]  ADDR_FS_HI    = 8'h18;
  localparam logic [7:0]  ADDR_FT_LO    = 8'h1c;
  localparam logic [7:0]  ADDR_FT_HI    = 8'h20;
  localparam logic [7:0]  ADDR_PC_LO    = 8'h24;
  localparam logic [7:0]  ADDR_PC_HI    = 8'h28;
  localparam logic [7:0]  ADDR_FPCSR    = 8'h2c;
  localparam logic [7:0]  ADDR_STATUS   = 8'h30;
  localparam logic [7:0]  ADDR_TGT_LO   = 8'h34;
  localparam logic [7:0]  ADDR_TGT_HI   = 8'h38;

  // instruction fields
  localparam int          OPC_LSB       = 26;
  localparam int          RS_LSB        = 21;
  localparam int          RT_LSB        = 16;
  localparam int          FMT_LSB       = 21;
  localparam int          CC_LSB        = 8;
  localparam int          ZERO_LSB      = 6;
  localparam int          TAG_LSB       = 4;
  localparam int          COND_LSB      = 0;
  localparam int          FUNC_LSB      = 0;
  localparam int          OFS_LSB       = 0;

  // encodings
  localparam logic [5:0]  OP_REG_IMM    = 6'h01;
  localparam logic [4:0]  RI_NEG_LIKELY = 5'h02;
  localparam logic [5:0]  OP_UNEQUAL    = 6'h05;
  localparam logic [5:0]  OP_UNEQ_LIKELY = 6'h15;
  localparam logic [5:0]  OP_SPECIAL    = 6'h00;
  localparam logic [5:0]  FN_BREAK      = 6'h0d;
  localparam logic [5:0]  OP_FP_COP     = 6'h11;
  localparam logic [1:0]  CMP_TAG       = 2'h3;
  localparam logic [4:0]  FMT_SINGLE    = 5'h10;
  localparam logic [4:0]  FMT_DOUBLE    = 5'h11;
  localparam logic [4:0]  FMT_PAIRED    = 5'h16;

  // float layouts
  localparam int          EXP_S         = 8;
  localparam int          MAN_S         = 23;
  localparam int          EXP_D         = 11;
  localparam int          MAN_D         = 52;

  // fp control/status layout
  localparam int          FPCSR_W       = 10;
  localparam int          FPCSR_CC_LSB  = 0;
  localparam int          FPCSR_FLAG    = 8;
  localparam int          FPCSR_EN      = 9;
  localparam logic [9:0]  RST_FPCSR     = 10'h000;
  localparam int          EVT_W         = 5;
  localparam logic [4:0]  RST_EVT       = 5'h00;
  localparam logic [31:0] RST_WORD      = 32'h0000_0000;
  localparam logic [63:0] RST_DWORD     = 64'h0000_0000_0000_0000;
  localparam logic [63:0] SLOT_STEP     = 64'h0000_0000_0000_0004;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SLOT = 2'b10
  } bbfc_state_t;

endpackage
